// file: rtl/icc_pkg.sv
/*
 * Shared constants and types for the input capture block: channel count,
 * buffer geometry, APB register map, capture modes and register layouts.
 * Assumes a 32-bit APB data path and byte addresses of eight bits.
 */
package icc_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int NUM_CH = 8;
	localparam int TB_W = 16;
	localparam int DEPTH = 4;
	localparam int PTR_W = 2;
	localparam int CNT_W = 3;
	localparam int PRE_W = 4;
	localparam int DMA_CH = 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int INT_W = 2 * NUM_CH;
	localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;
	localparam logic [PRE_W-1:0] PRE_LAST4 = 4'h3;
	localparam logic [PRE_W-1:0] PRE_LAST16 = 4'hf;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int GLOBAL_BIT = 7;
	localparam int CH_LSB = 4;
	localparam int CH_W = 3;
	localparam int OFF_W = 4;
	localparam logic [OFF_W-1:0] OFF_CTRL = 4'h0;
	localparam logic [OFF_W-1:0] OFF_BUF = 4'h4;
	localparam logic [OFF_W-1:0] OFF_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h80;
	localparam logic [ADDR_W-1:0] OFF_INT_CLR = 8'h84;
	localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h88;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_FALL,
		MODE_RISE,
		MODE_BOTH,
		MODE_RISE4,
		MODE_RISE16
	} icc_mode_t;

	typedef struct packed {
		logic dma_en;
		logic wake_en;
		logic [1:0] thr;
		logic tsel;
		icc_mode_t mode;
	} icc_ctrl_t;

	localparam int CTRL_W = $bits(icc_ctrl_t);
	localparam icc_ctrl_t CTRL_RST = '{dma_en: 1'b0, wake_en: 1'b0,
		thr: 2'h0, tsel: 1'b0, mode: MODE_OFF};

	typedef struct packed {
		logic ovf;
		logic [CNT_W-1:0] count;
	} icc_stat_t;

endpackage

// file: rtl/icc_buf_mem.sv
/*
 * Four-word capture buffer storage with a registered read port.
 * Assumes the caller keeps the pointers; read data lag the address by one
 * clock.
 */
`timescale 1ns/1ps
module icc_buf_mem (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic wr_en, // store wr_data
	input wire logic [icc_pkg::PTR_W-1:0] wr_addr, // write slot
	input wire logic [icc_pkg::TB_W-1:0] wr_data, // captured count
	input wire logic [icc_pkg::PTR_W-1:0] rd_addr, // head slot
	output logic [icc_pkg::TB_W-1:0] rd_data // head entry, registered
);

	logic [icc_pkg::TB_W-1:0] mem_r [icc_pkg::DEPTH];

	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem_r[rd_addr];
		end
	end

endmodule // icc_buf_mem

// file: rtl/icc_edge_det.sv
/*
 * Edge qualifier for one capture pin: simple, both-edge and prescaled
 * rising-edge modes, one registered pulse per qualifying event.
 * Assumes the pin is already synchronous to pclk.
 */
`timescale 1ns/1ps
module icc_edge_det (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic capture_input_pin, // capture pin level
	input wire icc_pkg::icc_mode_t mode, // edge mode of the channel
	output logic edge_evt // one-cycle qualifying event
);

	logic pin_d_r;
	logic [icc_pkg::PRE_W-1:0] pre_r;
	logic [icc_pkg::PRE_W-1:0] pre_last;
	logic rise;
	logic fall;
	logic pre_mode;
	logic hit;

	assign rise = capture_input_pin & ~pin_d_r;
	assign fall = ~capture_input_pin & pin_d_r;
	assign pre_mode = (mode == icc_pkg::MODE_RISE4) ||
		(mode == icc_pkg::MODE_RISE16);
	assign pre_last = (mode == icc_pkg::MODE_RISE4) ?
		icc_pkg::PRE_LAST4 : icc_pkg::PRE_LAST16;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_d_r <= 1'b0;
		end else begin
			pin_d_r <= capture_input_pin;
		end
	end

	// rising-edge divider, cleared outside the prescaled modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= '0;
		end else if (!pre_mode) begin
			pre_r <= '0;
		end else if (rise) begin
			pre_r <= (pre_r >= pre_last) ? '0 : pre_r + 1'b1;
		end
	end

	always_comb begin
		unique case (mode)
			icc_pkg::MODE_OFF: hit = 1'b0;
			icc_pkg::MODE_FALL: hit = fall;
			icc_pkg::MODE_RISE: hit = rise;
			icc_pkg::MODE_BOTH: hit = rise | fall;
			icc_pkg::MODE_RISE4,
			icc_pkg::MODE_RISE16: hit = rise && (pre_r >= pre_last);
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_evt <= 1'b0;
		end else begin
			edge_evt <= hit;
		end
	end

endmodule // icc_edge_det

// file: rtl/icc_capture_top.sv
/*
 * Eight input capture channels behind an APB slave: edge qualification,
 * time base latch, four-entry buffers, interrupt and wake requests, DMA requests on channels 0 and 1.
 * Assumes both time bases count on pclk and pins are synchronous to it.
 */
`timescale 1ns/1ps
module icc_capture_top (
	input wire logic pclk, // system clock, 200 MHz
	input wire logic presetn, // async reset, active low
	input wire logic [icc_pkg::ADDR_W-1:0] paddr, // apb byte address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [icc_pkg::DATA_W-1:0] pwdata, // apb write data
	output logic [icc_pkg::DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [icc_pkg::NUM_CH-1:0] capture_input_pin, // pins
	input wire logic [icc_pkg::TB_W-1:0] first_time_base, // count A
	input wire logic [icc_pkg::TB_W-1:0] second_time_base, // count B
	output logic irq, // interrupt level
	output logic wake_req, // wake pulse
	output logic [icc_pkg::DMA_CH-1:0] dma_req // dma request level
);

	localparam int NUM_CH = icc_pkg::NUM_CH;
	localparam int CNT_W = icc_pkg::CNT_W;
	localparam int CH_W = icc_pkg::CH_W;
	localparam int DATA_W = icc_pkg::DATA_W;
	localparam int INT_W = icc_pkg::INT_W;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic ch_hit(input logic [icc_pkg::ADDR_W-1:0] a,
		input logic [icc_pkg::OFF_W-1:0] off);
		return !a[icc_pkg::GLOBAL_BIT] && (a[icc_pkg::OFF_W-1:0] == off);
	endfunction

	function automatic logic [DATA_W-1:0] zext_ch(input int v);
		return DATA_W'(v);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	icc_pkg::icc_ctrl_t ctrl_r [NUM_CH];
	logic [CNT_W-1:0] cnt_r [NUM_CH];
	logic [CNT_W-1:0] cnt_nxt [NUM_CH];
	logic [icc_pkg::PTR_W-1:0] wr_ptr_r [NUM_CH];
	logic [icc_pkg::PTR_W-1:0] rd_ptr_r [NUM_CH];
	logic [icc_pkg::TB_W-1:0] head [NUM_CH];
	logic [NUM_CH-1:0] evt;
	logic [NUM_CH-1:0] push;
	logic [NUM_CH-1:0] pop;
	logic [NUM_CH-1:0] thr_hit;
	logic [NUM_CH-1:0] ovf_r;
	logic [NUM_CH-1:0] ctrl_we;
	logic [NUM_CH-1:0] wake_mask;
	logic [INT_W-1:0] int_stat_r;
	logic [INT_W-1:0] int_en_r;
	logic [CH_W-1:0] sel_ch;
	logic access_done;
	logic access_first;
	logic int_clr_we;
	logic int_en_we;
	logic [DATA_W-1:0] rd_val;
	logic rd_err;

	assign sel_ch = paddr[icc_pkg::CH_LSB +: CH_W];
	assign access_first = psel & penable & ~pready;
	assign access_done = psel & penable & pready;
	assign int_clr_we = access_done & pwrite &
		(paddr == icc_pkg::OFF_INT_CLR);
	assign int_en_we = access_done & pwrite &
		(paddr == icc_pkg::OFF_INT_EN);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		logic this_ch;

		assign this_ch = (sel_ch == CH_W'(g));
		assign ctrl_we[g] = access_done & pwrite & this_ch &
			ch_hit(paddr, icc_pkg::OFF_CTRL);
		assign pop[g] = access_done & ~pwrite & this_ch &
			ch_hit(paddr, icc_pkg::OFF_BUF) & (cnt_r[g] != '0);
		assign push[g] = evt[g] & (cnt_r[g] != icc_pkg::CNT_FULL);
		assign thr_hit[g] = push[g] &
			(cnt_r[g] == CNT_W'(ctrl_r[g].thr));
		assign cnt_nxt[g] = cnt_r[g] + CNT_W'(push[g]) - CNT_W'(pop[g]);
		assign wake_mask[g] = ctrl_r[g].wake_en;

		icc_edge_det u_edge (
			.pclk(pclk),
			.presetn(presetn),
			.capture_input_pin(capture_input_pin[g]),
			.mode(ctrl_r[g].mode),
			.edge_evt(evt[g])
		);

		icc_buf_mem u_mem (
			.pclk(pclk),
			.presetn(presetn),
			.wr_en(push[g]),
			.wr_addr(wr_ptr_r[g]),
			.wr_data(ctrl_r[g].tsel ? second_time_base :
				first_time_base),
			.rd_addr(rd_ptr_r[g]),
			.rd_data(head[g])
		);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ctrl_r[g] <= icc_pkg::CTRL_RST;
			end else if (ctrl_we[g]) begin
				ctrl_r[g] <= icc_pkg::icc_ctrl_t'(pwdata[icc_pkg::CTRL_W-1:0]);
			end
		end

		// oldest first: head pointer walks in write order
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_r[g] <= '0;
				wr_ptr_r[g] <= '0;
				rd_ptr_r[g] <= '0;
			end else begin
				cnt_r[g] <= cnt_nxt[g];
				if (push[g]) begin
					wr_ptr_r[g] <= wr_ptr_r[g] + 1'b1;
				end
				if (pop[g]) begin
					rd_ptr_r[g] <= rd_ptr_r[g] + 1'b1;
				end
			end
		end

		// overflow: capture lost on full buffer, cleared by a control write
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ovf_r[g] <= 1'b0;
			end else begin
				ovf_r[g] <= (ovf_r[g] & ~ctrl_we[g]) |
					(evt[g] & (cnt_r[g] == icc_pkg::CNT_FULL));
			end
		end

		// --------------------------------------------------------
		// channel checks
		// --------------------------------------------------------
		a_fall_capture: assert property (
			(ctrl_r[g].mode == icc_pkg::MODE_FALL) &&
			$fell(capture_input_pin[g]) ##1
			(ctrl_r[g].mode == icc_pkg::MODE_FALL) |-> evt[g])
			else $error("falling edge not captured");
		a_rise_capture: assert property (
			(ctrl_r[g].mode == icc_pkg::MODE_RISE) &&
			$rose(capture_input_pin[g]) ##1
			(ctrl_r[g].mode == icc_pkg::MODE_RISE) |-> evt[g])
			else $error("rising edge not captured");
		a_both_capture: assert property (
			(ctrl_r[g].mode == icc_pkg::MODE_BOTH) &&
			!$stable(capture_input_pin[g]) ##1
			(ctrl_r[g].mode == icc_pkg::MODE_BOTH) |-> evt[g])
			else $error("pin transition not captured");
		a_pre_on_rise: assert property (
			evt[g] && $past(ctrl_r[g].mode == icc_pkg::MODE_RISE16) |->
			$past(capture_input_pin[g]) && !$past(capture_input_pin[g], 2))
			else $error("prescaled capture without rising edge");
		a_buf_bound: assert property (
			cnt_r[g] <= icc_pkg::CNT_FULL)
			else $error("buffer count above depth");
		a_push_count: assert property (
			push[g] && !pop[g] |=> cnt_r[g] == $past(cnt_r[g]) + 1'b1)
			else $error("capture not counted");
		a_thr_flag: assert property (
			thr_hit[g] |=> int_stat_r[g] ##1 (irq || !int_en_r[g]))
			else $error("buffer level did not flag interrupt");
		a_edge_flag: assert property (
			evt[g] |=> int_stat_r[NUM_CH + g])
			else $error("edge event not flagged");
		a_wake_event: assert property (
			evt[g] && ctrl_r[g].wake_en |=> wake_req)
			else $error("wake not raised");
		a_pre4_on_rise: assert property (
			evt[g] && $past(ctrl_r[g].mode == icc_pkg::MODE_RISE4) |->
			$past(capture_input_pin[g]) &&
			!$past(capture_input_pin[g], 2))
			else $error("prescaled capture without rising edge");
		a_capture_value: assert property (
			push[g] && (cnt_r[g] == '0) |-> ##2 head[g] ==
			$past(ctrl_r[g].tsel ? second_time_base :
			first_time_base, 2))
			else $error("captured count not stored");
		a_pop_order: assert property (
			pop[g] |=> rd_ptr_r[g] == $past(rd_ptr_r[g]) + 1'b1)
			else $error("read pointer did not advance");
		a_pop_count: assert property (
			pop[g] && !push[g] |=> cnt_r[g] == $past(cnt_r[g]) - 1'b1)
			else $error("read not counted");
		a_full_drop: assert property (
			evt[g] && (cnt_r[g] == icc_pkg::CNT_FULL) |=> ovf_r[g])
			else $error("lost capture not flagged");
	end

	// ----------------------------------------------------------------
	// apb slave, one wait state
	// ----------------------------------------------------------------
	always_comb begin
		rd_val = '0;
		rd_err = 1'b0;
		if (!paddr[icc_pkg::GLOBAL_BIT]) begin
			case (paddr[icc_pkg::OFF_W-1:0])
				icc_pkg::OFF_CTRL: rd_val = DATA_W'(ctrl_r[sel_ch]);
				icc_pkg::OFF_BUF: begin
					rd_val = (cnt_r[sel_ch] != '0) ? DATA_W'(head[sel_ch]) : '0;
					rd_err = pwrite;
				end
				icc_pkg::OFF_STAT: begin
					rd_val = DATA_W'(icc_pkg::icc_stat_t'{ovf: ovf_r[sel_ch],
						count: cnt_r[sel_ch]});
					rd_err = pwrite;
				end
				default: rd_err = 1'b1;
			endcase
		end else begin
			case (paddr)
				icc_pkg::OFF_INT_STAT: begin
					rd_val = DATA_W'(int_stat_r);
					rd_err = pwrite;
				end
				icc_pkg::OFF_INT_CLR: rd_val = '0;
				icc_pkg::OFF_INT_EN: rd_val = DATA_W'(int_en_r);
				default: rd_err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= access_first;
			if (access_first) begin
				prdata <= pwrite ? '0 : rd_val;
				pslverr <= rd_err;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt, wake, dma
	// ----------------------------------------------------------------
	// low half: buffer level reached, high half: any edge event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat_r <= '0;
		end else begin
			int_stat_r <= (int_stat_r & ~(int_clr_we ? pwdata[INT_W-1:0] :
				'0)) | {evt, thr_hit};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_en_r <= '0;
		end else if (int_en_we) begin
			int_en_r <= pwdata[INT_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat_r & int_en_r);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_req <= 1'b0;
		end else begin
			wake_req <= |(evt & wake_mask);
		end
	end

	for (genvar d = 0; d < icc_pkg::DMA_CH; d++) begin : g_dma
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dma_req[d] <= 1'b0;
			end else begin
				dma_req[d] <= ctrl_r[d].dma_en & (cnt_nxt[d] != '0);
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_dma_level: assert property (
		ctrl_r[0].dma_en && (cnt_r[0] != '0) && !pop[0] |=> dma_req[0])
		else $error("dma request missing with data buffered");
	a_irq_cause: assert property (
		$rose(irq) |-> $past(|(int_stat_r & int_en_r)))
		else $error("interrupt without enabled status");
	a_irq_level: assert property (
		(|(int_stat_r & int_en_r)) |=> irq)
		else $error("enabled status without interrupt");
	a_wake_cause: assert property (
		wake_req |-> $past(|(evt & wake_mask)))
		else $error("wake without enabled event");
	a_dma_second: assert property (
		ctrl_r[1].dma_en && (cnt_r[1] != '0) && !pop[1] |=> dma_req[1])
		else $error("second dma request missing");

	c_full_buffer: cover property (push[0] && cnt_r[0] == 3'h3);
	c_overflow: cover property ($rose(ovf_r[0]));
	c_dma_pop: cover property (dma_req[1] ##[1:20] pop[1]);
	c_irq_rise: cover property ($rose(irq));
	c_rise16_hit: cover property (evt[5] &&
		ctrl_r[5].mode == icc_pkg::MODE_RISE16);

endmodule // icc_capture_top

// file: sim/icc_pin_drv.sv
/*
 * Far-side model: the signal source driving the eight capture pins.
 * Assumes the bench asks for at most one level change per pin per clock.
 */
`timescale 1ns/1ps
module icc_pin_drv (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic [7:0] req, // wanted pin levels
	output logic [7:0] pin // capture pins, synchronous to pclk
);
	// pins idle low out of reset, matching the edge detector's history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin <= 8'h00;
		else
			pin <= req;
	end
endmodule // icc_pin_drv

// file: sim/test_input_capture_channel.sv
/*
 * Self-checking bench for icc_capture_top with a queue model per channel.
 * Assumes the one-wait-state APB timing and capture latency of the design.
 */
`timescale 1ns/1ps
module test_input_capture_channel;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic wake_req;
	logic [1:0] dma_req;
	logic [7:0] req = 8'h00;
	logic [7:0] pins;
	logic [15:0] tba = 16'h0;
	logic [15:0] tbb = 16'h0;
	logic [31:0] seed = 32'h3c50e0a4;
	logic [31:0] rd;
	logic er;
	logic [31:0] cv;
	int err_total = 0;
	int tests_run = 0;
	int wakes = 0;
	int q[8][$];
	int pc[8];
	bit ov[8];

	always #2.5 pclk = ~pclk;

	icc_pin_drv drv (.pclk(pclk), .presetn(presetn), .req(req), .pin(pins));
	icc_capture_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_pin(pins), .first_time_base(tba),
		.second_time_base(tbb), .irq(irq), .wake_req(wake_req),
		.dma_req(dma_req));

	always @(posedge pclk) if (wake_req === 1'b1) wakes++;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// one pin toggle on channel c with fresh bases held around it
	task automatic tog(input int c, input int m, input logic ts);
		logic old;
		logic hit;
		logic [15:0] a;
		logic [15:0] b;
		old = req[c];
		{b, a} = xs();
		req[c] <= ~old;
		tba <= a;
		tbb <= b;
		repeat (5) @(posedge pclk);
		hit = (m == 1 && old) || (m == 2 && !old) || m == 3;
		if (m >= 4 && !old) begin
			pc[c]++;
			hit = (pc[c] % (m == 4 ? 4 : 16)) == 0;
		end
		if (hit) begin
			if (q[c].size() == 4)
				ov[c] = 1'b1;
			else
				q[c].push_back(ts ? b : a);
		end
	endtask

	task automatic drain(input int c);
		int n;
		n = q[c].size();
		apb(1'b0, 8'(16 * c + 8), 32'h0);
		chk(rd, {28'h0, ov[c], 3'(n)});
		repeat (n) begin
			apb(1'b0, 8'(16 * c + 4), 32'h0);
			chk(rd, q[c].pop_front());
		end
		apb(1'b0, 8'(16 * c + 4), 32'h0);
		chk(rd, 32'h0);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h70, 32'h0);
		chk(rd, 32'h0);
		chk({er, irq, dma_req}, 32'h0);
		for (int m = 1; m <= 5; m++) begin
			cv = {24'h0, m == 1, 3'h0, m[0], 3'(m)};
			apb(1'b1, 8'(16 * m), cv);
			apb(1'b0, 8'(16 * m), 32'h0);
			chk(rd, cv);
			for (int k = 0; k < 32; k++)
				tog(m, m, m[0]);
			chk(dma_req, {30'h0, m == 1, 1'b0});
			drain(m);
		end
		// undefined mode code: pin activity must not capture
		apb(1'b1, 8'h60, 32'h6);
		tog(6, 0, 1'b0);
		tog(6, 0, 1'b0);
		drain(6);
		apb(1'b0, 8'h80, 32'h0);
		chk(rd, 32'h3e3e);
		apb(1'b1, 8'h84, 32'hffff);
		apb(1'b1, 8'h88, 32'h0001);
		apb(1'b1, 8'h00, 32'he2);
		for (int k = 0; k < 4; k++)
			tog(0, 2, 1'b0);
		chk(irq, 1'b0);
		chk(dma_req, 2'b01);
		tog(0, 2, 1'b0);
		tog(0, 2, 1'b0);
		chk(irq, 1'b1);
		apb(1'b0, 8'h80, 32'h0);
		chk(rd, 32'h0101);
		chk(wakes, 3);
		apb(1'b1, 8'h84, 32'h0001);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, 8'h88, 32'h0100);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		apb(1'b1, 8'h88, 32'h0);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		drain(0);
		chk(dma_req, 2'b00);
		apb(1'b0, 8'h90, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		apb(1'b1, 8'h04, 32'h5);
		chk(er, 1'b1);
		apb(1'b0, 8'h84, 32'h0);
		chk(rd, 32'h0);
		// mid-run reset returns control and outputs to idle
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		chk({irq, wake_req, dma_req}, 32'h0);
		report_and_stop();
	end
endmodule // test_input_capture_channel
